// *** core/req_ind_engine.sv ***
// Request queue interpreter and indication queue writer of the slave controller.
// Function
// - Pointers are 8-bit segments; address is segment times 32 plus offset.
// - Net length above buffer data length earns a no-resource answer.
// - Device owns request read pointer; software owns request write pointer.
// - Equal pointers mean empty; one entry always stays unused.
// - Code 10h starts, 11h stops, 12h loads ready time from value byte.
// - Code 15h asks to leave the bus master relationship.
// - Code 20h controls watchdog: 00h reset, 01h enable, 02h disable.
// - A completed stop request posts a confirmation indication.
// - Stop confirmation waits for idle link and offline media access part.
// - Indication entries are 3 bytes and each raises the entry interrupt.
// - A full indication queue drops the entry and raises overflow.
// - Indication overflow never changes bus behaviour.
// - Device owns indication write pointer; software owns its read pointer.
// - Indication 81h marks stop done, 84h marks watchdog expiry.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module req_ind_engine (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Register port.
  input wire logic [fbq_pkg::REG_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Shared RAM port, read data one cycle after the read strobe.
  output logic [fbq_pkg::PHYS_W-1:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic ram_we,
  output logic ram_re,
  input wire logic [7:0] ram_rdata,
  // Media access part control and state.
  input wire logic link_busy,
  input wire logic link_offline,
  output logic link_start,
  output logic link_stop,
  output logic ready_time_load,
  output logic [7:0] ready_time,
  output logic leave_master,
  // User watchdog.
  input wire logic wd_expired,
  output logic wd_reset,
  output logic wd_enable,
  // Buffer length check on received requests.
  input wire logic chk_valid,
  input wire logic [7:0] chk_net_len,
  input wire logic [7:0] chk_buf_len,
  output logic no_resource,
  // Queue events toward software.
  output logic indication_entry_interrupt,
  output logic indication_overflow_interrupt
);
  typedef enum {IDLE, FETCH, WAITR, CAPT, EXEC, STOP_WAIT, IND_CHK, IND_WR, IND_DONE} state_t;

  state_t state_ff;
  logic [7:0] req_seg_ff, req_len_ff, req_wr_ff, req_rd_ff;
  logic [7:0] ind_seg_ff, ind_len_ff, ind_rd_ff, ind_wr_ff;
  logic [7:0] post_cnt_ff, code_ff, value_ff, ind_code_ff;
  logic [1:0] idx_ff;
  logic wd_pend_ff;
  logic [7:0] reg_rdata_ff;
  logic [fbq_pkg::PHYS_W-1:0] ram_addr_ff;
  logic [7:0] ram_wdata_ff, ready_time_ff;
  logic ram_we_ff, ram_re_ff, link_start_ff, link_stop_ff, ready_time_load_ff;
  logic leave_master_ff, wd_reset_ff, wd_enable_ff, no_resource_ff;
  logic ind_entry_irq_ff, ind_ovf_irq_ff;
  logic [7:0] req_nxt, ind_nxt, fetch_off, store_off;
  logic req_empty, ind_full, consume, post, stop_ready;

  seg_addr_if req_sa ();
  seg_addr_if ind_sa ();

  // Both queues share one address former design.
  assign req_sa.seg = req_seg_ff;
  assign req_sa.off = fetch_off;
  assign ind_sa.seg = ind_seg_ff;
  assign ind_sa.off = store_off;
  seg_addr_former u_req_addr (.sa(req_sa.former));
  seg_addr_former u_ind_addr (.sa(ind_sa.former));

  // Pointer stepping for both rings.
  ring_step #(.STEP(fbq_pkg::REQ_ENTRY_BYTES)) u_req_step (
    .ptr(req_rd_ff),
    .len(req_len_ff),
    .nxt(req_nxt)
  );
  ring_step #(.STEP(fbq_pkg::IND_ENTRY_BYTES)) u_ind_step (
    .ptr(ind_wr_ff),
    .len(ind_len_ff),
    .nxt(ind_nxt)
  );

  // Entries never straddle the ring end, since lengths are whole entries.
  assign fetch_off = req_rd_ff + {6'h00, idx_ff};
  assign store_off = ind_wr_ff + {6'h00, idx_ff};
  assign req_empty = (req_rd_ff == req_wr_ff);
  assign ind_full = (ind_nxt == ind_rd_ff);
  assign consume = (state_ff == EXEC);
  assign post = reg_wr && (reg_addr == fbq_pkg::REG_POST);
  assign stop_ready = !link_busy && link_offline;

  // Software-owned configuration and pointers; device-owned ones are read only.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      req_seg_ff <= fbq_pkg::ZERO_BYTE;
      req_len_ff <= fbq_pkg::ZERO_BYTE;
      req_wr_ff <= fbq_pkg::ZERO_BYTE;
      ind_seg_ff <= fbq_pkg::ZERO_BYTE;
      ind_len_ff <= fbq_pkg::ZERO_BYTE;
      ind_rd_ff <= fbq_pkg::ZERO_BYTE;
    end else if (reg_wr) begin
      unique case (reg_addr)
        fbq_pkg::REG_REQ_SEG: req_seg_ff <= reg_wdata;
        fbq_pkg::REG_REQ_LEN: req_len_ff <= reg_wdata;
        fbq_pkg::REG_REQ_WR: req_wr_ff <= reg_wdata;
        fbq_pkg::REG_IND_SEG: ind_seg_ff <= reg_wdata;
        fbq_pkg::REG_IND_LEN: ind_len_ff <= reg_wdata;
        fbq_pkg::REG_IND_RD: ind_rd_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata_ff <= fbq_pkg::ZERO_BYTE;
    end else if (!reg_rd) begin
      reg_rdata_ff <= fbq_pkg::ZERO_BYTE;
    end else begin
      unique case (reg_addr)
        fbq_pkg::REG_REQ_SEG: reg_rdata_ff <= req_seg_ff;
        fbq_pkg::REG_REQ_LEN: reg_rdata_ff <= req_len_ff;
        fbq_pkg::REG_REQ_WR: reg_rdata_ff <= req_wr_ff;
        fbq_pkg::REG_REQ_RD: reg_rdata_ff <= req_rd_ff;
        fbq_pkg::REG_IND_SEG: reg_rdata_ff <= ind_seg_ff;
        fbq_pkg::REG_IND_LEN: reg_rdata_ff <= ind_len_ff;
        fbq_pkg::REG_IND_RD: reg_rdata_ff <= ind_rd_ff;
        fbq_pkg::REG_IND_WR: reg_rdata_ff <= ind_wr_ff;
        fbq_pkg::REG_STATUS: reg_rdata_ff <= {4'h0, wd_pend_ff, wd_enable_ff,
                                              state_ff != IDLE, link_offline};
        fbq_pkg::REG_READY_TIME: reg_rdata_ff <= ready_time_ff;
        default: reg_rdata_ff <= fbq_pkg::ZERO_BYTE;
      endcase
    end
  end

  // Posts not yet consumed; a post in the consume cycle keeps the count.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      post_cnt_ff <= fbq_pkg::ZERO_BYTE;
    end else if (post && !consume && post_cnt_ff != 8'hFF) begin
      post_cnt_ff <= post_cnt_ff + 8'h01;
    end else if (consume && !post && post_cnt_ff != 8'h00) begin
      post_cnt_ff <= post_cnt_ff - 8'h01;
    end
  end

  // Watchdog expiry is held until the idle sequencer takes it, even into a full queue; a new expiry beats the clear.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wd_pend_ff <= 1'b0;
    end else if (wd_expired) begin
      wd_pend_ff <= 1'b1;
    end else if (state_ff == IDLE) begin
      wd_pend_ff <= 1'b0;
    end
  end

  // Sequencer: fetch code and value byte, act, then confirm where needed.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= IDLE;
      idx_ff <= 2'h0;
      code_ff <= fbq_pkg::ZERO_BYTE;
      value_ff <= fbq_pkg::ZERO_BYTE;
      ind_code_ff <= fbq_pkg::ZERO_BYTE;
    end else begin
      unique case (state_ff)
        IDLE: begin
          idx_ff <= 2'h0;
          if (wd_pend_ff) begin
            ind_code_ff <= fbq_pkg::IND_WD_EXPIRED;
            state_ff <= IND_CHK;
          end else if (post_cnt_ff != 8'h00 && !req_empty) begin
            state_ff <= FETCH;
          end
        end
        FETCH: state_ff <= WAITR;
        WAITR: state_ff <= CAPT;
        CAPT: begin
          if (idx_ff == 2'h0) begin
            code_ff <= ram_rdata;
            idx_ff <= 2'h1;
            state_ff <= FETCH;
          end else begin
            value_ff <= ram_rdata;
            state_ff <= EXEC;
          end
        end
        EXEC: begin
          idx_ff <= 2'h0;
          state_ff <= (code_ff == fbq_pkg::CODE_STOP) ? STOP_WAIT : IDLE;
        end
        STOP_WAIT: begin
          if (stop_ready) begin
            ind_code_ff <= fbq_pkg::IND_STOP_DONE;
            state_ff <= IND_CHK;
          end
        end
        IND_CHK: state_ff <= ind_full ? IDLE : IND_WR;
        IND_WR: begin
          idx_ff <= idx_ff + 2'h1;
          if (idx_ff == 2'h2) begin
            state_ff <= IND_DONE;
          end
        end
        IND_DONE: state_ff <= IDLE;
      endcase
    end
  end

  // Device-owned pointers step by one entry and wrap at the length.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      req_rd_ff <= fbq_pkg::ZERO_BYTE;
      ind_wr_ff <= fbq_pkg::ZERO_BYTE;
    end else begin
      if (consume) begin
        req_rd_ff <= req_nxt;
      end
      if (state_ff == IND_DONE) begin
        ind_wr_ff <= ind_nxt;
      end
    end
  end

  // RAM strobes; an indication entry is code then two zero value bytes.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ram_addr_ff <= '0;
      ram_wdata_ff <= fbq_pkg::ZERO_BYTE;
      ram_we_ff <= 1'b0;
      ram_re_ff <= 1'b0;
    end else begin
      ram_re_ff <= (state_ff == FETCH);
      ram_we_ff <= (state_ff == IND_WR);
      if (state_ff == FETCH) begin
        ram_addr_ff <= req_sa.phys;
      end else if (state_ff == IND_WR) begin
        ram_addr_ff <= ind_sa.phys;
        ram_wdata_ff <= (idx_ff == 2'h0) ? ind_code_ff : fbq_pkg::ZERO_BYTE;
      end
    end
  end

  // Request decode; unknown codes fall through and are only skipped.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link_start_ff <= 1'b0;
      link_stop_ff <= 1'b0;
      ready_time_load_ff <= 1'b0;
      ready_time_ff <= fbq_pkg::ZERO_BYTE;
      leave_master_ff <= 1'b0;
      wd_reset_ff <= 1'b0;
      wd_enable_ff <= 1'b0;
    end else begin
      link_start_ff <= consume && code_ff == fbq_pkg::CODE_START;
      link_stop_ff <= consume && code_ff == fbq_pkg::CODE_STOP;
      ready_time_load_ff <= consume && code_ff == fbq_pkg::CODE_READY_TIME;
      leave_master_ff <= consume && code_ff == fbq_pkg::CODE_LEAVE;
      wd_reset_ff <= consume && code_ff == fbq_pkg::CODE_WATCHDOG
                     && value_ff == fbq_pkg::WD_RESET;
      if (consume && code_ff == fbq_pkg::CODE_READY_TIME) begin
        ready_time_ff <= value_ff;
      end
      if (consume && code_ff == fbq_pkg::CODE_WATCHDOG) begin
        if (value_ff == fbq_pkg::WD_ENABLE) begin
          wd_enable_ff <= 1'b1;
        end else if (value_ff == fbq_pkg::WD_DISABLE) begin
          wd_enable_ff <= 1'b0;
        end
      end
    end
  end

  // Overflow drops the entry and pulses the overflow interrupt; the link, leave and watchdog outputs are left untouched.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ind_entry_irq_ff <= 1'b0;
      ind_ovf_irq_ff <= 1'b0;
    end else begin
      ind_entry_irq_ff <= (state_ff == IND_DONE);
      ind_ovf_irq_ff <= (state_ff == IND_CHK) && ind_full;
    end
  end

  // Received data longer than the buffer, or than any buffer, is refused.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      no_resource_ff <= 1'b0;
    end else begin
      no_resource_ff <= chk_valid && (chk_net_len > chk_buf_len
                        || chk_net_len > fbq_pkg::BUF_MAX_BYTES);
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign ram_addr = ram_addr_ff;
  assign ram_wdata = ram_wdata_ff;
  assign ram_we = ram_we_ff;
  assign ram_re = ram_re_ff;
  assign link_start = link_start_ff;
  assign link_stop = link_stop_ff;
  assign ready_time_load = ready_time_load_ff;
  assign ready_time = ready_time_ff;
  assign leave_master = leave_master_ff;
  assign wd_reset = wd_reset_ff;
  assign wd_enable = wd_enable_ff;
  assign no_resource = no_resource_ff;
  assign indication_entry_interrupt = ind_entry_irq_ff;
  assign indication_overflow_interrupt = ind_ovf_irq_ff;

  // Expected address built independently of the former, for checking.
  logic [fbq_pkg::PHYS_W-1:0] exp_addr;
  assign exp_addr = {req_seg_ff, 5'h00} + {5'h00, fetch_off};

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_ind_write;
    !ram_we_ff ##1 ram_we_ff [*3] ##1 !ram_we_ff;
  endsequence

  property p_addr;
    state_ff == FETCH |=> ram_re_ff && ram_addr_ff == $past(exp_addr);
  endproperty
  a_addr: assert property (p_addr) else $error("Fetch address wrong.");

  property p_no_res;
    chk_valid && chk_net_len > chk_buf_len |=> no_resource_ff;
  endproperty
  a_no_res: assert property (p_no_res) else $error("Missing no-resource.");

  property p_start;
    consume && code_ff == fbq_pkg::CODE_START |=> link_start_ff && !link_stop_ff;
  endproperty
  a_start: assert property (p_start) else $error("Start not issued.");

  property p_ready_time;
    consume && code_ff == fbq_pkg::CODE_READY_TIME
      |=> ready_time_load_ff && ready_time_ff == $past(value_ff);
  endproperty
  a_ready_time: assert property (p_ready_time) else $error("Ready time lost.");

  property p_leave;
    leave_master_ff |-> $past(consume) && $past(code_ff) == fbq_pkg::CODE_LEAVE;
  endproperty
  a_leave: assert property (p_leave) else $error("Leave pulse without cause.");

  property p_wd;
    consume && code_ff == fbq_pkg::CODE_WATCHDOG && value_ff == fbq_pkg::WD_ENABLE
      |=> wd_enable_ff;
  endproperty
  a_wd: assert property (p_wd) else $error("Watchdog not enabled.");

  property p_stop_wait;
    state_ff == STOP_WAIT && !stop_ready |=> state_ff == STOP_WAIT;
  endproperty
  a_stop_wait: assert property (p_stop_wait) else $error("Early stop confirm.");

  property p_entry;
    state_ff == IND_CHK && !ind_full |=> s_ind_write and (##4 ind_entry_irq_ff);
  endproperty
  a_entry: assert property (p_entry) else $error("Entry write wrong.");

  property p_overflow;
    state_ff == IND_CHK && ind_full |=> ind_ovf_irq_ff && !ram_we_ff ##1 !ram_we_ff;
  endproperty
  a_overflow: assert property (p_overflow) else $error("Overflow not handled.");

  property p_advance;
    consume |=> req_rd_ff == (({1'b0, $past(req_rd_ff)} + {1'b0, fbq_pkg::REQ_ENTRY_BYTES}
                 >= {1'b0, $past(req_len_ff)}) ? 8'h00
                 : 8'($past(req_rd_ff) + fbq_pkg::REQ_ENTRY_BYTES));
  endproperty
  a_advance: assert property (p_advance) else $error("Read pointer step wrong.");
endmodule
`default_nettype wire

// *** core/fbq_pkg.sv ***
// Shared constants for the request and indication queue engine.
package fbq_pkg;
  // Segment addressing of the shared RAM.
  localparam int SEG_W = 8;
  localparam int OFF_W = 8;
  localparam int SEG_SHIFT = 5;
  localparam int PHYS_W = 13;
  // Queue entry sizes in bytes.
  localparam logic [7:0] REQ_ENTRY_BYTES = 8'h05;
  localparam logic [7:0] IND_ENTRY_BYTES = 8'h03;
  // A buffer data field holds bytes 0 through 243.
  localparam logic [7:0] BUF_MAX_BYTES = 8'hF4;
  // Request codes.
  localparam logic [7:0] CODE_START = 8'h10;
  localparam logic [7:0] CODE_STOP = 8'h11;
  localparam logic [7:0] CODE_READY_TIME = 8'h12;
  localparam logic [7:0] CODE_LEAVE = 8'h15;
  localparam logic [7:0] CODE_WATCHDOG = 8'h20;
  // Watchdog control values.
  localparam logic [7:0] WD_RESET = 8'h00;
  localparam logic [7:0] WD_ENABLE = 8'h01;
  localparam logic [7:0] WD_DISABLE = 8'h02;
  // Indication codes.
  localparam logic [7:0] IND_STOP_DONE = 8'h81;
  localparam logic [7:0] IND_WD_EXPIRED = 8'h84;
  // Register offsets on the plain register port.
  localparam int REG_AW = 4;
  localparam logic [3:0] REG_REQ_SEG = 4'h0;
  localparam logic [3:0] REG_REQ_LEN = 4'h1;
  localparam logic [3:0] REG_REQ_WR = 4'h2;
  localparam logic [3:0] REG_REQ_RD = 4'h3;
  localparam logic [3:0] REG_POST = 4'h4;
  localparam logic [3:0] REG_IND_SEG = 4'h5;
  localparam logic [3:0] REG_IND_LEN = 4'h6;
  localparam logic [3:0] REG_IND_RD = 4'h7;
  localparam logic [3:0] REG_IND_WR = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'h9;
  localparam logic [3:0] REG_READY_TIME = 4'hA;
  // Reset value of every pointer, length and segment.
  localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage

// *** core/seg_addr_if.sv ***
// Segment plus offset address request and its physical answer.
`timescale 1ns/1ps
`default_nettype none
interface seg_addr_if;
  logic [fbq_pkg::SEG_W-1:0] seg;
  logic [fbq_pkg::OFF_W-1:0] off;
  logic [fbq_pkg::PHYS_W-1:0] phys;
  modport former (input seg, input off, output phys);
  modport user (output seg, output off, input phys);
endinterface
`default_nettype wire

// *** core/seg_addr_former.sv ***
// Forms a physical RAM address from a segment pointer and an offset.
`timescale 1ns/1ps
`default_nettype none
module seg_addr_former (
  // Address request and answer.
  seg_addr_if.former sa
);
  // The shifted segment alone must fit the physical address; the offset is not counted.
  initial begin
    if (fbq_pkg::SEG_W + fbq_pkg::SEG_SHIFT > fbq_pkg::PHYS_W) begin
      $error("Physical address too narrow for the segment.");
    end
  end

  // Segments step in 32-byte units, so the shift is fixed.
  assign sa.phys = (fbq_pkg::PHYS_W'(sa.seg) << fbq_pkg::SEG_SHIFT)
                   + fbq_pkg::PHYS_W'(sa.off);
endmodule
`default_nettype wire

// *** core/ring_step.sv ***
// Advances a circular queue offset by one entry and wraps at the length.
`timescale 1ns/1ps
`default_nettype none
module ring_step #(
  parameter logic [7:0] STEP = 8'h01
) (
  // Current offset and queue length.
  input wire logic [7:0] ptr,
  input wire logic [7:0] len,
  // Offset of the following entry.
  output logic [7:0] nxt
);
  logic [8:0] sum;

  initial begin
    if (STEP == 8'h00) begin
      $error("Entry size must not be zero.");
    end
  end

  // A nine-bit sum keeps a carry from aliasing onto a small offset.
  assign sum = {1'b0, ptr} + {1'b0, STEP};
  assign nxt = (sum >= {1'b0, len}) ? 8'h00 : sum[7:0];
endmodule
`default_nettype wire

// *** test/shared_ram_model.sv ***
// Shared RAM partner holding both queues, answering reads one cycle late.
`timescale 1ns/1ps
`default_nettype none
module shared_ram_model (
  // Clock.
  input wire logic clock,
  // Device side of the RAM.
  input wire logic [12:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  input wire logic ram_we,
  input wire logic ram_re,
  output logic [7:0] ram_rdata
);
  logic [7:0] mem [0:8191];
  initial ram_rdata = 8'h00;
  // Outside a read answer the bus is inverted, so a stale byte never passes.
  always @(posedge clock) begin
    if (ram_we) begin
      mem[ram_addr] <= ram_wdata;
    end
    if (ram_re) begin
      ram_rdata <= mem[ram_addr];
    end else begin
      ram_rdata <= ~ram_rdata;
    end
  end
endmodule
`default_nettype wire

// *** test/test_fieldbus_slave_request_indication_queues.sv ***
// Self-checking bench of the request and indication queue engine.
`timescale 1ns/1ps
`default_nettype none
module test_fieldbus_slave_request_indication_queues;
  logic clock, rst, reg_wr, reg_rd, link_busy, link_offline, wd_expired, chk_valid;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, ram_wdata, ram_rdata, ready_time, net, bl;
  logic [12:0] ram_addr;
  logic ram_we, ram_re, link_start, link_stop, rt_load, leave, wd_reset, wd_enable;
  logic no_res, ind_int, ovf_int;
  logic [7:0] rseg, iseg, rptr, v, seen;
  logic [12:0] re_q [$];
  int failures, checked, i, k, tot;
  int cnt [0:6] = '{default: 0};
  logic [7:0] codes [0:6] = '{8'h10, 8'h12, 8'h15, 8'h20, 8'h20, 8'h20, 8'h33};
  logic [7:0] vals [0:6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00};
  int kidx [0:6] = '{0, 2, 3, 7, 7, 4, 7};

  req_ind_engine dut_u (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_re(ram_re), .ram_rdata(ram_rdata),
    .link_busy(link_busy), .link_offline(link_offline), .link_start(link_start),
    .link_stop(link_stop), .ready_time_load(rt_load), .ready_time(ready_time),
    .leave_master(leave), .wd_expired(wd_expired), .wd_reset(wd_reset),
    .wd_enable(wd_enable), .chk_valid(chk_valid), .chk_net_len(net), .chk_buf_len(bl),
    .no_resource(no_res), .indication_entry_interrupt(ind_int),
    .indication_overflow_interrupt(ovf_int));
  shared_ram_model ram_u (.clock(clock), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_we(ram_we), .ram_re(ram_re), .ram_rdata(ram_rdata));

  // Clock of 10 ns.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Pulse counters and a log of RAM read addresses.
  always @(posedge clock) begin
    cnt[0] <= cnt[0] + int'(link_start);
    cnt[1] <= cnt[1] + int'(link_stop);
    cnt[2] <= cnt[2] + int'(rt_load);
    cnt[3] <= cnt[3] + int'(leave);
    cnt[4] <= cnt[4] + int'(wd_reset);
    cnt[5] <= cnt[5] + int'(ind_int);
    cnt[6] <= cnt[6] + int'(ovf_int);
    if (ram_re === 1'b1) begin
      re_q.push_back(ram_addr);
    end
  end

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  function automatic logic [7:0] step(input logic [7:0] p);
    return (p + 8'h05 >= 8'h0F) ? 8'h00 : p + 8'h05;
  endfunction

  // Places one entry, moves the write pointer with wrap and posts it once.
  task automatic post(input logic [7:0] code, input logic [7:0] val);
    logic [7:0] nx;
    nx = step(rptr);
    ram_u.mem[{rseg, 5'h00} + 13'(rptr)] = code;
    ram_u.mem[{rseg, 5'h00} + 13'(rptr) + 13'h1] = val;
    re_q.delete();
    wr(fbq_pkg::REG_REQ_WR, nx);
    wr(fbq_pkg::REG_POST, 8'($urandom));
    repeat (20) @(posedge clock);
    check(16'(re_q[0]), 16'({rseg, 5'h00} + 13'(rptr)));
    rd(fbq_pkg::REG_REQ_RD, seen);
    check(seen, nx);
    rptr = nx;
  endtask

  task automatic wd_pulse();
    @(posedge clock);
    wd_expired <= 1'b1;
    @(posedge clock);
    wd_expired <= 1'b0;
    repeat (20) @(posedge clock);
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // A full run needs about 400 cycles; a hang is cut short well after that.
  initial begin
    #200us;
    failures++;
    results();
  end

  initial begin
    void'($urandom(32'h9459));
    {rst, reg_wr, reg_rd, link_busy, link_offline, wd_expired, chk_valid} = 7'b1000000;
    {reg_addr, reg_wdata, net, bl, rptr} = '0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    // Every register and the unmapped places read 00 after reset.
    for (i = 0; i < 16; i++) begin
      rd(4'(i), seen);
      check(seen, 8'h00);
    end
    // Read-only pointers ignore writes.
    wr(fbq_pkg::REG_REQ_RD, 8'h0A);
    wr(fbq_pkg::REG_IND_WR, 8'h06);
    rd(fbq_pkg::REG_REQ_RD, seen);
    check(seen, 8'h00);
    rd(fbq_pkg::REG_IND_WR, seen);
    check(seen, 8'h00);
    rseg = 8'($urandom_range(1, 240));
    iseg = 8'($urandom_range(1, 240));
    wr(fbq_pkg::REG_REQ_SEG, rseg);
    wr(fbq_pkg::REG_REQ_LEN, 8'h0F);
    wr(fbq_pkg::REG_IND_SEG, iseg);
    wr(fbq_pkg::REG_IND_LEN, 8'h09);
    // Each request code but stop, watchdog values and an undefined code, wrapping the queue.
    for (i = 0; i < 7; i++) begin
      v = (i == 1) ? 8'($urandom) : vals[i];
      tot = cnt[0] + cnt[1] + cnt[2] + cnt[3] + cnt[4];
      k = (kidx[i] < 7) ? cnt[kidx[i]] : 0;
      post(codes[i], v);
      check(cnt[0] + cnt[1] + cnt[2] + cnt[3] + cnt[4], tot + int'(kidx[i] < 7));
      if (kidx[i] < 7) begin
        check(cnt[kidx[i]], k + 1);
      end
      if (i == 1) begin
        check(ready_time, v);
        rd(fbq_pkg::REG_READY_TIME, seen);
        check(seen, v);
      end
      if (i == 3 || i == 4) begin
        check(wd_enable, i == 3);
      end
    end
    // Stop confirmation waits for an idle, offline media access part.
    @(posedge clock);
    link_busy <= 1'b1;
    post(fbq_pkg::CODE_STOP, 8'($urandom));
    check(cnt[1], 1);
    check(cnt[5], 0);
    @(posedge clock);
    link_busy <= 1'b0;
    link_offline <= 1'b1;
    repeat (20) @(posedge clock);
    check(cnt[5], 1);
    check(ram_u.mem[{iseg, 5'h00}], fbq_pkg::IND_STOP_DONE);
    check(ram_u.mem[{iseg, 5'h00} + 13'h2], 8'h00);
    rd(fbq_pkg::REG_IND_WR, seen);
    check(seen, 8'h03);
    // Idle engine, watchdog off, media access part offline.
    rd(fbq_pkg::REG_STATUS, seen);
    check(seen, 8'h01);
    wd_pulse();
    check(ram_u.mem[{iseg, 5'h00} + 13'h3], fbq_pkg::IND_WD_EXPIRED);
    // Queue now full: the entry is dropped and overflow raised.
    ram_u.mem[{iseg, 5'h00} + 13'h6] = 8'h5A;
    wd_pulse();
    check(cnt[6], 1);
    check(cnt[5], 2);
    check(ram_u.mem[{iseg, 5'h00} + 13'h6], 8'h5A);
    rd(fbq_pkg::REG_IND_WR, seen);
    check(seen, 8'h06);
    wr(fbq_pkg::REG_IND_RD, 8'h03);
    wd_pulse();
    check(ram_u.mem[{iseg, 5'h00} + 13'h6], fbq_pkg::IND_WD_EXPIRED);
    rd(fbq_pkg::REG_IND_WR, seen);
    check(seen, 8'h00);
    // Length check against buffer header and the 244-byte field.
    for (i = 0; i < 20; i++) begin
      v = (i == 0) ? 8'hF4 : (i == 1) ? 8'hF5 : 8'($urandom);
      @(posedge clock);
      chk_valid <= 1'b1;
      net <= v;
      bl <= (i < 2) ? 8'hFF : (i == 2) ? v : 8'($urandom);
      @(posedge clock);
      chk_valid <= 1'b0;
      #1 check(no_res, (net > bl) || (net > fbq_pkg::BUF_MAX_BYTES));
    end
    results();
  end
endmodule
`default_nettype wire
